/* File: hdl/regs_pkg.sv */
// How it works
// - Generation bit 13 set sends the chosen high-speed pattern, else normal.
// - Check bit 12 set verifies received data against the chosen pattern.
// - Select bits 10:8 pick high, low, mixed, long or short random pattern.
// - Select values 101, 110, 111 pick PRBS 7, 23, 31; resets to 101.
// - Pattern errors seen while checking are counted for the station to read.
// - Low-speed PRBS bits 5:4 pick 31, reserved, 7, 23; resets to 10.
// - Test bit 3 puts the channel in deep far loopback.
// - Clock register bits 11:8 clear each lane transmit FIFO, then self-clear.
// - Lane three clock bits 3:2 pick lane 0, lane 2 or own clock.
// - Lane two clock bit 1 picks lane 0 clock or own; resets 0.
// - Lane one clock bit 0 picks lane 0 clock or own; resets 0.
// - Reset register bits 11:8 clear each lane receive FIFO.
// - Self-clearing reset bits return to zero the cycle after a one is written.
// - Bit 6 clears receive FIFO b, bit 5 clears receive FIFO a; default 0.
// - Writing one to bit 4 restarts link training; zero is normal.
// - Bit 3 resets transmit and receive logic but not the registers.
package regs_pkg;

    localparam logic [4:0] addr_hs_test = 5'h0B;
    localparam logic [4:0] addr_clock_sel = 5'h0D;
    localparam logic [4:0] addr_reset_ctl = 5'h0E;
    localparam logic [4:0] addr_err_tally = 5'h10;

    localparam logic [15:0] hs_test_reset = 16'h0520;
    localparam logic [15:0] clock_sel_reset = 16'h0000;
    localparam logic [15:0] reset_ctl_reset = 16'h0000;
    localparam logic [15:0] err_tally_reset = 16'hFFFD;

    // Writable bit masks; others read zero
    localparam logic [15:0] hs_test_mask = 16'h373F;
    localparam logic [15:0] clock_sel_mask = 16'hFFFF;
    localparam logic [15:0] reset_ctl_mask = 16'hFFFF;
    // Self-clearing bits
    localparam logic [15:0] clock_sel_sc = 16'hFF00;
    localparam logic [15:0] reset_ctl_sc = 16'h0F78;

    localparam int gen_bit = 13;
    localparam int check_bit = 12;
    localparam int choice_hi = 10;
    localparam int choice_lo = 8;
    localparam int ls_prbs_hi = 5;
    localparam int ls_prbs_lo = 4;
    localparam int loopback_bit = 3;
    localparam int lane_fifo_hi = 11;
    localparam int lane_fifo_lo = 8;
    localparam int lane_three_hi = 3;
    localparam int lane_three_lo = 2;
    localparam int lane_two_bit = 1;
    localparam int lane_one_bit = 0;
    localparam int hs_b_bit = 6;
    localparam int hs_a_bit = 5;
    localparam int train_bit = 4;
    localparam int datapath_bit = 3;

    localparam logic [1:0] op_write = 2'h1;
    localparam logic [1:0] op_read = 2'h2;

    // Lane clock sources
    typedef enum logic [1:0] {src_lane0, src_lane2, src_own} lane_src_t;

    // Pattern choice decode
    typedef enum logic [3:0] {
        pat_high, pat_low, pat_mixed, pat_compliant_long, pat_compliant_short,
        pat_prbs7, pat_prbs23, pat_prbs31, pat_reserved
    } pattern_t;

    function automatic pattern_t hs_pattern(input logic [2:0] sel);
        unique case (sel)
            3'h0: hs_pattern = pat_high;
            3'h1: hs_pattern = pat_low;
            3'h2: hs_pattern = pat_mixed;
            3'h3: hs_pattern = pat_compliant_long;
            3'h4: hs_pattern = pat_compliant_short;
            3'h5: hs_pattern = pat_prbs7;
            3'h6: hs_pattern = pat_prbs23;
            3'h7: hs_pattern = pat_prbs31;
        endcase
    endfunction

    function automatic pattern_t ls_prbs(input logic [1:0] sel);
        unique case (sel)
            2'h0: ls_prbs = pat_prbs31;
            2'h1: ls_prbs = pat_reserved;
            2'h2: ls_prbs = pat_prbs7;
            2'h3: ls_prbs = pat_prbs23;
        endcase
    endfunction

endpackage

/* File: hdl/access_if.sv */
`timescale 1ns/10ps
// Decoded register access between the top and the tally counter
interface access_if;
    logic read_tally;
    logic [15:0] tally;
    modport owner (output read_tally, input tally);
    modport counter (input read_tally, output tally);
endinterface

/* File: hdl/error_tally.sv */
`timescale 1ns/10ps
module error_tally
    import regs_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Error events
    input wire logic count_on,
    input wire logic error_hit,
    // Register side
    access_if.counter acc
);
    logic [15:0] tally_q;
    logic [15:0] tally_d;

    // Saturating count, cleared on read; an error in the read cycle survives
    always_comb
    begin
        tally_d = tally_q;
        if (acc.read_tally)
            tally_d = 16'h0000;
        if (count_on && error_hit && (tally_d != 16'hFFFF))
            tally_d = tally_d + 16'h0001;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            tally_q <= err_tally_reset;
        else
            tally_q <= tally_d;
    end

    assign acc.tally = tally_q;
endmodule

/* File: hdl/channel_regs.sv */
`timescale 1ns/10ps
module channel_regs
    import regs_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Management access, one cycle per request
    input wire logic [1:0] op,
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output logic rvalid,
    // Pattern errors from the checker
    input wire logic hs_pattern_error,
    // Test controls
    output logic hs_pattern_gen_on,
    output logic hs_pattern_check_on,
    output pattern_t hs_pattern_choice,
    output pattern_t ls_prbs_choice,
    output logic deep_far_loopback,
    // Lane clocks
    output lane_src_t lane_three_clock_choice,
    output lane_src_t lane_two_clock_choice,
    output lane_src_t lane_one_clock_choice,
    // Reset strobes
    output logic [3:0] ls_tx_lane_fifo_clear,
    output logic [3:0] ls_rx_lane_fifo_clear,
    output logic hs_rx_b_fifo_clear,
    output logic hs_rx_a_fifo_clear,
    output logic link_training_restart,
    output logic datapath_reset
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] hs_test_q, hs_test_d;
    logic [15:0] clock_sel_q, clock_sel_d;
    logic [15:0] reset_ctl_q, reset_ctl_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic pattern_err_q, pattern_err_d;
    // Test control outputs
    logic gen_on_q, gen_on_d;
    logic check_on_q, check_on_d;
    pattern_t hs_choice_q, hs_choice_d;
    pattern_t ls_choice_q, ls_choice_d;
    logic loopback_q, loopback_d;
    // Lane clock outputs
    lane_src_t lane_three_q, lane_three_d;
    lane_src_t lane_two_q, lane_two_d;
    lane_src_t lane_one_q, lane_one_d;
    // Reset strobe outputs
    logic [3:0] tx_clear_q, tx_clear_d;
    logic [3:0] rx_clear_q, rx_clear_d;
    logic hs_b_clear_q, hs_b_clear_d;
    logic hs_a_clear_q, hs_a_clear_d;
    logic restart_q, restart_d;
    logic datapath_q, datapath_d;
    access_if acc ();

    ////////////////////////////////////////////////////////////////////////
    // Field layout checks; the strobe ports are four lanes wide
    // Refuse a field layout that no longer fits the fixed port widths
    if (lane_fifo_hi - lane_fifo_lo != 3)
    begin : g_bad_lane_field
        $error("lane FIFO field must span four bits");
    end
    if (lane_three_hi - lane_three_lo != 1)
    begin : g_bad_lane_three_field
        $error("lane three clock field must span two bits");
    end

    ////////////////////////////////////////////////////////////////////////
    // Lane clock source from a single select bit: own clock or lane 0
    function automatic lane_src_t single_lane_src(input logic own_sel);
        single_lane_src = own_sel ? src_own : src_lane0;
    endfunction

    // Lane three: upper bit picks its own clock, else the lower bit picks
    // Every select code maps to a source, so no illegal code exists
    function automatic lane_src_t lane_three_src(input logic [1:0] sel);
        if (sel[1])
            lane_three_src = src_own;
        else if (sel[0])
            lane_three_src = src_lane2;
        else
            lane_three_src = src_lane0;
    endfunction

    error_tally u_tally (
        .clock(clock),
        .rst(rst),
        .count_on(hs_test_q[check_bit]),
        .error_hit(pattern_err_q),
        .acc(acc)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register writes and self-clearing
    always_comb
    begin
        hs_test_d = hs_test_q;
        clock_sel_d = clock_sel_q & ~clock_sel_sc;
        reset_ctl_d = reset_ctl_q & ~reset_ctl_sc;
        if (op == op_write)
        begin
            unique case (addr)
                addr_hs_test: hs_test_d = wdata & hs_test_mask;
                addr_clock_sel: clock_sel_d = wdata & clock_sel_mask;
                addr_reset_ctl: reset_ctl_d = wdata & reset_ctl_mask;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            hs_test_q <= hs_test_reset;
            clock_sel_q <= clock_sel_reset;
            reset_ctl_q <= reset_ctl_reset;
        end
        else
        begin
            hs_test_q <= hs_test_d;
            clock_sel_q <= clock_sel_d;
            reset_ctl_q <= reset_ctl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path, answer one cycle after the request
    assign acc.read_tally = (op == op_read) && (addr == addr_err_tally);

    always_comb
    begin
        rvalid_d = (op == op_read);
        rdata_d = 16'h0000;
        if (op == op_read)
        begin
            unique case (addr)
                addr_hs_test: rdata_d = hs_test_q;
                addr_clock_sel: rdata_d = clock_sel_q;
                addr_reset_ctl: rdata_d = reset_ctl_q;
                addr_err_tally: rdata_d = acc.tally;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;

    ////////////////////////////////////////////////////////////////////////
    // Error pulse captured once before the tally counts it
    always_comb
    begin
        pattern_err_d = hs_pattern_error;
    end

    // One flop keeps the checker's timing path away from the tally adder
    always_ff @(posedge clock)
    begin
        if (rst)
            pattern_err_q <= 1'b0;
        else
            pattern_err_q <= pattern_err_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers load from the next register values, so every
    // control still follows its register bit in the cycle after a write

    // Test controls from the next pattern register value
    always_comb
    begin
        gen_on_d = hs_test_d[gen_bit];
        check_on_d = hs_test_d[check_bit];
        hs_choice_d = hs_pattern(hs_test_d[choice_hi:choice_lo]);
        ls_choice_d = ls_prbs(hs_test_d[ls_prbs_hi:ls_prbs_lo]);
        loopback_d = hs_test_d[loopback_bit];
    end

    // Reset values decode the pattern register reset word
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            gen_on_q <= hs_test_reset[gen_bit];
            check_on_q <= hs_test_reset[check_bit];
            hs_choice_q <= hs_pattern(hs_test_reset[choice_hi:choice_lo]);
            ls_choice_q <= ls_prbs(hs_test_reset[ls_prbs_hi:ls_prbs_lo]);
            loopback_q <= hs_test_reset[loopback_bit];
        end
        else
        begin
            gen_on_q <= gen_on_d;
            check_on_q <= check_on_d;
            hs_choice_q <= hs_choice_d;
            ls_choice_q <= ls_choice_d;
            loopback_q <= loopback_d;
        end
    end

    // Lane clock sources from the next clock select value
    always_comb
    begin
        lane_three_d = lane_three_src(clock_sel_d[lane_three_hi:lane_three_lo]);
        lane_two_d = single_lane_src(clock_sel_d[lane_two_bit]);
        lane_one_d = single_lane_src(clock_sel_d[lane_one_bit]);
    end

    // Reset values decode the clock select reset word
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            lane_three_q <= lane_three_src(clock_sel_reset[lane_three_hi:lane_three_lo]);
            lane_two_q <= single_lane_src(clock_sel_reset[lane_two_bit]);
            lane_one_q <= single_lane_src(clock_sel_reset[lane_one_bit]);
        end
        else
        begin
            lane_three_q <= lane_three_d;
            lane_two_q <= lane_two_d;
            lane_one_q <= lane_one_d;
        end
    end

    // Per-lane FIFO clears, one bit of each self-clearing field per lane
    for (genvar lane = 0; lane <= lane_fifo_hi - lane_fifo_lo; lane++)
    begin : g_lane
        assign tx_clear_d[lane] = clock_sel_d[lane_fifo_lo + lane];
        assign rx_clear_d[lane] = reset_ctl_d[lane_fifo_lo + lane];
    end

    // Strobes stand exactly one cycle since their source bits self-clear
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tx_clear_q <= clock_sel_reset[lane_fifo_hi:lane_fifo_lo];
            rx_clear_q <= reset_ctl_reset[lane_fifo_hi:lane_fifo_lo];
        end
        else
        begin
            tx_clear_q <= tx_clear_d;
            rx_clear_q <= rx_clear_d;
        end
    end

    // High-speed FIFO, training and datapath strobes
    always_comb
    begin
        hs_b_clear_d = reset_ctl_d[hs_b_bit];
        hs_a_clear_d = reset_ctl_d[hs_a_bit];
        restart_d = reset_ctl_d[train_bit];
        // Datapath only; management registers keep their values
        datapath_d = reset_ctl_d[datapath_bit];
    end

    // Reset values decode the reset control reset word
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            hs_b_clear_q <= reset_ctl_reset[hs_b_bit];
            hs_a_clear_q <= reset_ctl_reset[hs_a_bit];
            restart_q <= reset_ctl_reset[train_bit];
            datapath_q <= reset_ctl_reset[datapath_bit];
        end
        else
        begin
            hs_b_clear_q <= hs_b_clear_d;
            hs_a_clear_q <= hs_a_clear_d;
            restart_q <= restart_d;
            datapath_q <= datapath_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from their flip-flops
    assign hs_pattern_gen_on = gen_on_q;
    assign hs_pattern_check_on = check_on_q;
    assign hs_pattern_choice = hs_choice_q;
    assign ls_prbs_choice = ls_choice_q;
    assign deep_far_loopback = loopback_q;
    assign lane_three_clock_choice = lane_three_q;
    assign lane_two_clock_choice = lane_two_q;
    assign lane_one_clock_choice = lane_one_q;
    assign ls_tx_lane_fifo_clear = tx_clear_q;
    assign ls_rx_lane_fifo_clear = rx_clear_q;
    assign hs_rx_b_fifo_clear = hs_b_clear_q;
    assign hs_rx_a_fifo_clear = hs_a_clear_q;
    assign link_training_restart = restart_q;
    assign datapath_reset = datapath_q;
endmodule

/* File: test/regs_monitor.sv */
`timescale 1ns/10ps
module regs_monitor
    import regs_pkg::*;
(
    // Clock, reset, bus
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] op,
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic rvalid,
    // Controls
    input wire logic hs_pattern_gen_on,
    input wire logic hs_pattern_check_on,
    input wire logic deep_far_loopback,
    input wire lane_src_t lane_one_clock_choice,
    input wire logic [3:0] ls_tx_lane_fifo_clear,
    input wire logic [3:0] ls_rx_lane_fifo_clear,
    input wire logic hs_rx_b_fifo_clear,
    input wire logic hs_rx_a_fifo_clear,
    input wire logic link_training_restart,
    input wire logic datapath_reset
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic w_hs, w_clk, w_rst;
    logic [7:0] strobes;
    ////////////////////////////////////////////////////////////////
    // Write decodes
    assign w_hs = op == op_write && addr == addr_hs_test;
    assign w_clk = op == op_write && addr == addr_clock_sel;
    assign w_rst = op == op_write && addr == addr_reset_ctl;
    assign strobes = {ls_rx_lane_fifo_clear, hs_rx_b_fifo_clear, hs_rx_a_fifo_clear,
        link_training_restart, datapath_reset};
    // Register behaviour
    AST_READ_VALID: assert property (op == op_read |=> rvalid)
        else $error("read not answered");
    AST_GEN: assert property (w_hs |=> hs_pattern_gen_on == $past(wdata[13]))
        else $error("gen bit wrong");
    AST_CHECK: assert property (w_hs |=> hs_pattern_check_on == $past(wdata[12]))
        else $error("check bit wrong");
    AST_LOOP: assert property (w_hs |=> deep_far_loopback == $past(wdata[3]))
        else $error("loopback bit wrong");
    AST_TX_SET: assert property (w_clk |=> ls_tx_lane_fifo_clear == $past(wdata[11:8]))
        else $error("tx clear wrong");
    AST_TX_CAUSE: assert property (|ls_tx_lane_fifo_clear |-> $past(w_clk))
        else $error("tx clear held");
    AST_RST_SET: assert property (w_rst |=> strobes == $past({wdata[11:8], wdata[6:3]}))
        else $error("reset strobes wrong");
    AST_SC: assert property (|strobes |-> $past(w_rst))
        else $error("strobe not self cleared");
    AST_LANE1: assert property (w_clk |=> lane_one_clock_choice ==
        ($past(wdata[0]) ? src_own : src_lane0)) else $error("lane one source wrong");
    // Main scenarios
    cover property (w_hs);
    cover property (datapath_reset);
    cover property (|ls_tx_lane_fifo_clear);
endmodule
bind channel_regs regs_monitor u_mon (.*);

/* File: test/station_model.sv */
`timescale 1ns/10ps
module station_model
    import regs_pkg::*;
(
    // Bus side
    input wire logic clock,
    output logic [1:0] op,
    output logic [4:0] addr,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    ////////////////////////////////////////////////////////////////
    // Idle bus
    initial
    begin
        op = 2'h0;
        addr = 5'h00;
        wdata = 16'h0000;
    end
    // One-cycle write of the data as given, bus scrambled after
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clock);
        op = op_write;
        addr = a;
        wdata = d;
        @(negedge clock);
        op = 2'h0;
        addr = ~a;
        wdata = ~d;
    endtask
    // One-cycle read, data taken the cycle after
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clock);
        op = op_read;
        addr = a;
        @(negedge clock);
        d = rdata;
        op = 2'h0;
        addr = ~a;
    endtask
endmodule

/* File: test/test_test_clock_reset_ctrl_regs.sv */
`timescale 1ns/10ps
module test_test_clock_reset_ctrl_regs;
    import regs_pkg::*;
    logic clock, rst, hs_pattern_error, rvalid, hs_pattern_gen_on, hs_pattern_check_on;
    logic deep_far_loopback, hs_rx_b_fifo_clear, hs_rx_a_fifo_clear;
    logic link_training_restart, datapath_reset;
    logic [1:0] op;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, v;
    logic [3:0] ls_tx_lane_fifo_clear, ls_rx_lane_fifo_clear;
    pattern_t hs_pattern_choice, ls_prbs_choice;
    lane_src_t lane_three_clock_choice, lane_two_clock_choice, lane_one_clock_choice;
    int errors, total_checks;
    pattern_t hs_exp[8] = '{pat_high, pat_low, pat_mixed, pat_compliant_long, pat_compliant_short,
        pat_prbs7, pat_prbs23, pat_prbs31};
    pattern_t ls_exp[4] = '{pat_prbs31, pat_reserved, pat_prbs7, pat_prbs23};
    lane_src_t l3_exp[4] = '{src_lane0, src_lane2, src_own, src_own};
    channel_regs u_dut (.*);
    station_model u_st (.*);
    ////////////////////////////////////////////////////////////////
    // Compare and verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        if (errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Clock and watchdog
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial
    begin
        #20000;
        errors++;
        finish_test;
    end
    // Test sequence
    initial
    begin
        rst = 1'b1;
        hs_pattern_error = 1'b0;
        errors = 0;
        total_checks = 0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        u_st.rd(addr_hs_test, v);
        chk(v, 16'h0520);
        chk(hs_pattern_choice, pat_prbs7);
        chk(ls_prbs_choice, pat_prbs7);
        u_st.rd(addr_clock_sel, v);
        chk(v, 16'h0000);
        u_st.rd(addr_reset_ctl, v);
        chk(v, 16'h0000);
        u_st.rd(addr_err_tally, v);
        chk(v, 16'hFFFD);
        // Every pattern code and flag mix
        for (int i = 0; i < 8; i++)
        begin
            u_st.wr(addr_hs_test, {2'h0, i[1:0], 1'b0, i[2:0], 2'h0, i[1:0], i[2], 3'h0});
            chk(hs_pattern_choice, hs_exp[i]);
            chk(ls_prbs_choice, ls_exp[i % 4]);
            chk({hs_pattern_gen_on, hs_pattern_check_on}, i[1:0]);
            chk(deep_far_loopback, i[2]);
        end
        // Lane clock sources
        for (int k = 0; k < 4; k++)
        begin
            u_st.wr(addr_clock_sel, {12'h000, k[1:0], k[0], k[0]});
            chk(lane_three_clock_choice, l3_exp[k]);
            chk(lane_two_clock_choice, k[0] ? src_own : src_lane0);
            chk(lane_one_clock_choice, k[0] ? src_own : src_lane0);
        end
        // Self-clearing FIFO and datapath strobes
        for (int j = 5; j < 11; j += 5)
        begin
            u_st.wr(addr_clock_sel, {4'h0, j[3:0], 8'h03});
            chk(ls_tx_lane_fifo_clear, j[3:0]);
            @(negedge clock);
            chk(ls_tx_lane_fifo_clear, 4'h0);
            u_st.wr(addr_reset_ctl, {4'h0, j[3:0], 1'b0, j[3:0], 3'h0});
            chk({ls_rx_lane_fifo_clear, hs_rx_b_fifo_clear, hs_rx_a_fifo_clear,
                link_training_restart, datapath_reset}, {j[3:0], j[3:0]});
            @(negedge clock);
            chk({ls_rx_lane_fifo_clear, hs_rx_b_fifo_clear, hs_rx_a_fifo_clear,
                link_training_restart, datapath_reset}, 16'h0);
        end
        u_st.rd(addr_clock_sel, v);
        chk(v, 16'h0003);
        u_st.rd(addr_reset_ctl, v);
        chk(v, 16'h0000);
        u_st.rd(addr_hs_test, v);
        chk(v, 16'h3738);
        // Pattern errors counted, then cleared by read
        repeat (3)
        begin
            @(negedge clock);
            hs_pattern_error = 1'b1;
            @(negedge clock);
            hs_pattern_error = 1'b0;
        end
        repeat (3) @(negedge clock);
        u_st.rd(addr_err_tally, v);
        chk(v, 16'h0003);
        u_st.rd(addr_err_tally, v);
        chk(v, 16'h0000);
        u_st.rd(5'h1F, v);
        chk(v, 16'h0000);
        finish_test;
    end
endmodule
